// ### src/sleep_wake_control.sv
`timescale 1ns/10ps
`include "sleep_wake_map.svh"
module sleep_wake_control
  import sleep_wake_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  input  wire logic        sleepExec,
  input  wire logic [14:0] progCounter,
  input  wire logic        busCollision2Event,
  input  wire logic        serialPort2Event,
  input  wire logic        masterClearReq,
  input  wire logic        brownoutReq,
  input  wire logic        powerOnReq,
  input  wire logic        watchdogExpired,
  input  wire logic        oscClockPin,
  input  wire logic        lowFreqOscIn,
  output logic             cpuClockEn,
  output logic             lowFreqOscEn,
  output logic             pinHoldEn,
  output logic             wdtClear,
  output logic             wdtRunInSleep,
  output logic             deviceReset,
  output logic [14:0]      prefetchAddr,
  output logic             resumeReq,
  output logic             vectorReq,
  output logic [14:0]      vectorAddr,
  output logic             wakeRequest
);
  state_t s_q;
  state_t s_d;
  logic   resetSrc;
  logic   pendingIrq;

  // Wake cause treated as a reset: the core clears itself on deviceReset
  assign resetSrc = masterClearReq | brownoutReq | powerOnReq;  // R8 R10
  // Both flag sources gated by their own enable; global enable ignored
  assign pendingIrq = |(s_q.flags[1:0] & s_q.enables[1:0]);  // R11 R23

  assign cpuClockEn    = (s_q.phase == AWAKE) || (s_q.phase == RESUME);  // R5
  assign lowFreqOscEn  = 1'b1;  // R6
  assign pinHoldEn     = s_q.pinHold;  // R7
  assign wdtClear      = s_q.wdtClear;
  assign wdtRunInSleep = (s_q.phase == ASLEEP) && s_q.sleepCfg[`BIT_WDT_SLEEP];  // R2
  assign deviceReset   = resetSrc;  // R10
  assign prefetchAddr  = progCounter + 15'h0001;  // R12
  assign resumeReq     = (s_q.phase == RESUME);  // R13
  assign vectorReq     = s_q.vectorReq;
  assign vectorAddr    = `ISR_VECTOR;  // R13
  assign wakeRequest   = pendingIrq;
  assign regRdData     = s_q.rdData;

  always_comb begin
    s_d = s_q;
    s_d.wdtClear = 1'b0;
    s_d.vectorReq = 1'b0;
    s_d.osc1 = oscClockPin;
    s_d.osc2 = s_q.osc1;
    s_d.oscPrev = s_q.osc2;
    // Flags: software writes, hardware set wins a same-cycle clear
    if (regWrite && regAddr == `OFS_FLAGS4) begin
      s_d.flags = {6'h00, regWrData[1:0]};  // R21
    end
    if (busCollision2Event) begin
      s_d.flags[`BIT_BUSCOL2] = 1'b1;  // R19 R22
    end
    if (serialPort2Event) begin
      s_d.flags[`BIT_SERIAL2] = 1'b1;  // R20 R22
    end
    if (regWrite && regAddr == `OFS_ENABLES4) begin
      s_d.enables = {6'h00, regWrData[1:0]};
    end
    if (regWrite && regAddr == `OFS_INTCTL) begin
      s_d.intCtl = regWrData;
    end
    if (regWrite && regAddr == `OFS_SLEEPCFG) begin
      s_d.sleepCfg = {6'h00, regWrData[1:0]};
    end
    // Status flags are set only by this block's events
    if (regRead) begin
      unique case (regAddr)
        `OFS_FLAGS4:   s_d.rdData = {6'h00, s_q.flags[1:0]};  // R21
        `OFS_ENABLES4: s_d.rdData = s_q.enables;
        `OFS_INTCTL:   s_d.rdData = s_q.intCtl;
        `OFS_STATUS:   s_d.rdData = s_q.status;  // R17
        `OFS_SLEEPCFG: s_d.rdData = s_q.sleepCfg;
        default:       s_d.rdData = 8'h00;
      endcase
    end
    unique case (s_q.phase)
      AWAKE: begin
        if (sleepExec) begin  // R1
          if (pendingIrq) begin
            s_d.phase = AWAKE;  // R15
          end else begin
            s_d.phase = ASLEEP;
            s_d.pinHold = 1'b1;  // R7
            s_d.wdtClear = 1'b1;  // R2
            s_d.status[`BIT_PWRDOWN] = 1'b0;  // R3
            s_d.status[`BIT_TIMEOUT] = 1'b1;  // R4
          end
        end
      end
      ASLEEP: begin
        // Sampled every cycle, so a flag set during entry wakes at once
        if (pendingIrq || watchdogExpired) begin  // R9 R16
          s_d.wdtClear = 1'b1;  // R14
          s_d.pinHold = 1'b0;
          s_d.ostCount = 11'd0;
          if (watchdogExpired) begin
            s_d.status[`BIT_TIMEOUT] = 1'b0;
          end
          s_d.phase = s_q.sleepCfg[`BIT_CRYSTAL] ? STARTUP : RESUME;  // R18
        end
      end
      STARTUP: begin
        s_d.wdtClear = 1'b1;
        if (s_q.osc2 && !s_q.oscPrev) begin
          s_d.ostCount = s_q.ostCount + 11'd1;
          if (s_q.ostCount == `OST_PERIODS - 11'd1) begin  // R18
            s_d.phase = RESUME;
          end
        end
      end
      RESUME: begin
        // Prefetched instruction runs this cycle; vector follows
        s_d.vectorReq = s_q.intCtl[`BIT_GIE] && pendingIrq;  // R13
        s_d.phase = AWAKE;
      end
      default: s_d.phase = AWAKE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst || resetSrc) begin  // R10
      s_q <= '{phase: AWAKE, flags: `RST_FLAGS4, enables: `RST_ENABLES4,
               intCtl: `RST_INTCTL, status: `RST_STATUS, sleepCfg: `RST_SLEEPCFG,
               rdData: 8'h00, ostCount: 11'd0, osc1: 1'b0, osc2: 1'b0,
               oscPrev: 1'b0, pinHold: 1'b0, wdtClear: 1'b1, vectorReq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### src/sleep_wake_map.svh
// Notes on behaviour
// R1: Low power entered only by power-down instruction
// R2: Entry clears watchdog; runs if sleep-enabled
// R3: Completed entry clears power-down flag
// R4: Completed entry sets timeout flag
// R5: Processor clock gated while asleep
// R6: Low-frequency oscillator kept running while asleep
// R7: Pins hold their drive state asleep
// R8: Non-watchdog resets processed while asleep
// R9: Wake on resets, watchdog, enabled interrupts
// R10: Reset sources reset; watchdog/interrupt resume
// R11: Interrupt wakes if enabled, ignoring global enable
// R12: Next instruction prefetched at PC plus one
// R13: Run prefetched instruction, then vector if enabled
// R14: Watchdog cleared on every wake
// R15: Pending enabled interrupt makes instruction a no-op
// R16: Interrupt during instruction: complete, then wake
// R17: Power-down flag still set marks a no-op
// R18: Crystal modes wait 1024 oscillator periods
// R19: Bus collision flag bit 1, software clears
// R20: Serial port flag bit 0, software clears
// R21: Flag bits 7 to 2 read zero
// R22: Flags set regardless of enable bits
// R23: Wake request is OR of each flag ANDed with its enable
`ifndef SLEEP_WAKE_MAP_SVH
`define SLEEP_WAKE_MAP_SVH
`define OFS_FLAGS4      4'h0
`define OFS_ENABLES4    4'h1
`define OFS_INTCTL      4'h2
`define OFS_STATUS      4'h3
`define OFS_SLEEPCFG    4'h4
`define BIT_SERIAL2     0
`define BIT_BUSCOL2     1
`define BIT_GIE         7
`define BIT_TIMEOUT     4
`define BIT_PWRDOWN     3
`define BIT_CRYSTAL     0
`define BIT_WDT_SLEEP   1
`define RST_FLAGS4      8'h00
`define RST_ENABLES4    8'h00
`define RST_INTCTL      8'h00
`define RST_STATUS      8'h18
`define RST_SLEEPCFG    8'h00
`define ISR_VECTOR      15'h0004
`define OST_PERIODS     11'd1024
`endif

// ### src/sleep_wake_pkg.sv
package sleep_wake_pkg;
  typedef enum logic [3:0] {
    AWAKE = 4'b0001,
    ASLEEP = 4'b0010,
    STARTUP = 4'b0100,
    RESUME = 4'b1000
  } phase_t;
  typedef struct packed {
    phase_t      phase;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  intCtl;
    logic [7:0]  status;
    logic [7:0]  sleepCfg;
    logic [7:0]  rdData;
    logic [10:0] ostCount;
    logic        osc1, osc2, oscPrev;
    logic        pinHold;
    logic        wdtClear;
    logic        vectorReq;
  } state_t;
endpackage

// ### verification/core_model.sv
`timescale 1ns/10ps
// Core side: issues the power-down instruction only while its clock runs
module core_model (
  input  wire logic clock,
  input  wire logic go,
  input  wire logic cpuClockEn,
  output logic      sleepExec
);
  initial sleepExec = 1'b0;
  always @(posedge clock) sleepExec <= go && cpuClockEn;
endmodule

// ### verification/sleep_wake_control_monitor.sv
`timescale 1ns/10ps
module sleep_wake_control_monitor (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        sleepExec,
  input wire logic        wakeRequest,
  input wire logic        cpuClockEn,
  input wire logic        deviceReset,
  input wire logic        wdtClear,
  input wire logic        pinHoldEn,
  input wire logic        resumeReq,
  input wire logic        lowFreqOscEn,
  input wire logic        wdtRunInSleep,
  input wire logic [14:0] progCounter,
  input wire logic [14:0] prefetchAddr,
  input wire logic [14:0] vectorAddr
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_enter; sleepExec && cpuClockEn && !wakeRequest && !deviceReset
    |=> !cpuClockEn && pinHoldEn && wdtClear; endproperty
  a_enter: assert property (p_enter) else $error("entry");
  property p_noop; sleepExec && cpuClockEn && wakeRequest && !deviceReset |=> cpuClockEn; endproperty
  a_noop: assert property (p_noop) else $error("noop");
  property p_only; $fell(cpuClockEn) |-> $past(sleepExec); endproperty
  a_only: assert property (p_only) else $error("stray sleep");
  // Startup holds the clock low too, so the wake clear must already be up
  property p_wake; !cpuClockEn && pinHoldEn && wakeRequest && !deviceReset |=> wdtClear; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_res; resumeReq |-> cpuClockEn ##1 !resumeReq; endproperty
  a_res: assert property (p_res) else $error("resume");
  property p_pf; prefetchAddr == progCounter + 15'h1; endproperty
  a_pf: assert property (p_pf) else $error("prefetch");
  property p_vec; vectorAddr == 15'h0004; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_lfo; lowFreqOscEn; endproperty
  a_lfo: assert property (p_lfo) else $error("osc");
  // Sleep-only watchdog run must never be flagged while the core clock runs
  property p_wdtrun; cpuClockEn |-> !wdtRunInSleep; endproperty
  a_wdtrun: assert property (p_wdtrun) else $error("wdt run");
  property p_rst; deviceReset |=> cpuClockEn && !pinHoldEn; endproperty
  a_rst: assert property (p_rst) else $error("reset wake");
endmodule
bind sleep_wake_control sleep_wake_control_monitor mon (.*);

// ### verification/tb_sleep_wake_control.sv
`timescale 1ns/10ps
module tb_sleep_wake_control;
  logic        clock = 0, sysRst = 1, regWrite = 0, regRead = 0, go = 0, osc = 0;
  logic        busEv = 0, serEv = 0, wdtEx = 0, rdPend = 0, sleepExec, cpuClockEn, vectorReq;
  logic        wdtRun;
  logic [2:0]  rstSrc = 0;
  logic [3:0]  regAddr = 0;
  logic [7:0]  regWrData = 0, regRdData, vecs = 0;
  logic [14:0] pc = 0;
  logic [31:0] seed = 32'h98c6;
  logic [7:0]  expQ[$];
  int          miscompares = 0, samples_checked = 0, cycles = 0, n;
  always #4 clock = ~clock;
  sleep_wake_control dut (.clock(clock), .sys_rst(sysRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sleepExec(sleepExec), .progCounter(pc), .busCollision2Event(busEv),
    .serialPort2Event(serEv), .masterClearReq(rstSrc[0]), .brownoutReq(rstSrc[1]),
    .powerOnReq(rstSrc[2]), .watchdogExpired(wdtEx), .oscClockPin(osc), .lowFreqOscIn(osc),
    .cpuClockEn(cpuClockEn), .lowFreqOscEn(), .pinHoldEn(), .wdtClear(), .wdtRunInSleep(wdtRun),
    .deviceReset(), .prefetchAddr(), .resumeReq(), .vectorReq(vectorReq), .vectorAddr(),
    .wakeRequest());
  core_model core (.clock(clock), .go(go), .cpuClockEn(cpuClockEn), .sleepExec(sleepExec));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) regWrite <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock) regWrite <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock) regRead <= 1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clock) regRead <= 0;
  endtask
  // Random instruction addresses exercise the prefetch adder on every entry
  task automatic slp;
    seed = lfsr(seed);
    @(posedge clock) go <= 1;
    pc <= seed[14:0];
    @(posedge clock) go <= 0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic waitAwake(input int lim);
    n = 0;
    while (cpuClockEn !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    osc <= ~osc;
    if (rdPend) chk(regRdData, expQ.pop_front());
    rdPend <= regRead;
    vecs <= vecs + 8'(vectorReq);
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      summarize;
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    sysRst <= 0;
    rd(4'h3, 8'h18);
    @(posedge clock) busEv <= 1;
    @(posedge clock) busEv <= 0;
    rd(4'h0, 8'h02);
    wr(4'h0, 8'hfc);
    rd(4'h0, 8'h00);
    @(posedge clock) serEv <= 1;
    @(posedge clock) serEv <= 0;
    slp;
    chk({7'h0, cpuClockEn}, 8'h00);
    chk({7'h0, wdtRun}, 8'h00);
    rd(4'h3, 8'h10);
    wr(4'h1, 8'h01);
    waitAwake(20);
    chk({7'h0, cpuClockEn}, 8'h01);
    rd(4'h0, 8'h01);
    chk(vecs, 8'h00);
    wr(4'h0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      slp;
      chk({7'h0, cpuClockEn}, 8'h00);
      @(posedge clock) rstSrc <= 3'b001 << i;
      @(posedge clock) rstSrc <= 3'b000;
      rd(4'h3, 8'h18);
      rd(4'h1, 8'h00);
    end
    wr(4'h2, 8'h80);
    wr(4'h1, 8'h02);
    @(posedge clock) busEv <= 1;
    @(posedge clock) busEv <= 0;
    slp;
    chk({7'h0, cpuClockEn}, 8'h01);
    rd(4'h3, 8'h18);
    wr(4'h0, 8'h00);
    slp;
    @(posedge clock) busEv <= 1;
    @(posedge clock) busEv <= 0;
    waitAwake(20);
    rd(4'h3, 8'h10);
    // Counter updates on the edge the read task returns on; let it settle
    @(negedge clock);
    chk(vecs, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h03);
    slp;
    chk({7'h0, wdtRun}, 8'h01);
    @(posedge clock) wdtEx <= 1;
    @(posedge clock) wdtEx <= 0;
    waitAwake(3000);
    chk({7'h0, n >= 2040 && n <= 2070}, 8'h01);
    rd(4'h3, 8'h00);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h00);
    rd(4'hf, 8'h00);
    repeat (3) @(posedge clock);
    summarize;
  end
endmodule
